// file: design/ctcr_pkg.sv
// shared constants for the channel 2 trim and checksum register bank
package ctcr_pkg;
  // ---------------------------------------------------------------
  // register offsets (word addresses in the serial frame)
  // ---------------------------------------------------------------
  localparam logic [5:0] CTCR_OFS_CH2_OFFSET_TRIM_LOW = 6'h15;
  localparam logic [5:0] CTCR_OFS_CH2_GAIN_TRIM_HIGH = 6'h16;
  localparam logic [5:0] CTCR_OFS_CH2_GAIN_TRIM_LOW = 6'h17;
  localparam logic [5:0] CTCR_OFS_CONFIG_CHECKSUM = 6'h3e;
  localparam logic [5:0] CTCR_OFS_SPARE_WORD = 6'h3f;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] CTCR_RST_OFFSET_TRIM_LOW = 8'h00;
  localparam logic [15:0] CTCR_RST_GAIN_TRIM_HIGH = 16'h8000;
  localparam logic [7:0] CTCR_RST_GAIN_TRIM_LOW = 8'h00;
  localparam logic [15:0] CTCR_RST_CONFIG_CHECKSUM = 16'h0000;
  localparam logic [15:0] CTCR_RST_SPARE_WORD = 16'h0000;

  // ---------------------------------------------------------------
  // field positions and frame layout
  // ---------------------------------------------------------------
  localparam int CTCR_TRIM_LOW_MSB = 15;   // trim bits sit in 15:8
  localparam int CTCR_TRIM_LOW_LSB = 8;
  localparam int CTCR_CMD_READ_BIT = 15;   // 1 = read, 0 = write
  localparam int CTCR_CMD_ADDR_MSB = 5;    // address in 5:0
  localparam logic [4:0] CTCR_LAST_CMD_BIT = 5'h0f;
  localparam logic [4:0] CTCR_LAST_DATA_BIT = 5'h1f;
  localparam logic [15:0] CTCR_RSVD_ZERO = 16'h0000;
endpackage : ctcr_pkg

// file: design/ctcr_sync.sv
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module ctcr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic i_clk,               // sampling clock
  input wire logic i_rst,               // synchronous reset, high
  input wire logic [WIDTH-1:0] i_async, // raw pin levels
  output logic [WIDTH-1:0] o_sync       // levels after two stages
);
  logic [WIDTH-1:0] meta_q;

  // first stage feeds only the second; nothing else looks at it
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule : ctcr_sync

// file: design/ctcr_regs.sv
// channel 2 trim registers, map checksum and spare word behind a serial port
// Notes on behaviour
// - offset trim low: trim bits in 15:8, low byte reads zero.
// - gain trim high: read-write bits 23:8, resets to top bit only.
// - gain trim low: trim bits in 15:8, low byte reads zero.
// - checksum word read-only, zero after reset, writes ignored.
// - serial output undriven while chip select is high, lagging the pin by the two sync stages plus one register.
`timescale 1ns/1ns
module ctcr_regs
  import ctcr_pkg::*;
(
  input wire logic I_SYS_CLK,                         // 10 MHz system clock
  input wire logic I_RST,                             // synchronous reset, high
  input wire logic I_CS_N,                            // chip select pin, low active
  input wire logic I_SCLK,                            // serial clock pin
  input wire logic I_DIN,                             // serial data in pin
  output logic O_DOUT,                                // serial data out value
  output logic O_DOUT_OE_N,                           // data out enable, low drives
  output logic [7:0] O_CH2_OFFSET_TRIM_LOW_BITS,      // offset correction 7:0
  output logic [15:0] O_CH2_GAIN_TRIM_HIGH_BITS,      // gain correction 23:8
  output logic [7:0] O_CH2_GAIN_TRIM_LOW_BITS,        // gain correction 7:0
  output logic [15:0] O_CONFIG_CHECKSUM               // register map checksum
);
  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [2:0] pins_s;
  logic cs_n_s;
  logic sclk_s;
  logic din_s;

  ctcr_sync #(.WIDTH(3), .RST_VAL(3'h4)) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_async({I_CS_N, I_SCLK, I_DIN}),
    .o_sync(pins_s)
  );
  assign cs_n_s = pins_s[2];
  assign sclk_s = pins_s[1];
  assign din_s = pins_s[0];

  // ---------------------------------------------------------------
  // serial clock edge detection
  // ---------------------------------------------------------------
  logic sclk_prev_q;
  logic sclk_rise;
  logic sclk_fall;

  // edges come from the synchronised copy, so they lag the pin by 2-3 cycles
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev_q & ~cs_n_s;

  // ---------------------------------------------------------------
  // frame shifter: 16 command bits then 16 data bits
  // ---------------------------------------------------------------
  logic [4:0] bit_cnt_q;
  logic [15:0] shift_in_q;
  logic [15:0] cmd_q;
  logic cmd_load;
  logic wr_stb;
  logic [15:0] wr_data;
  logic [5:0] cmd_addr;
  logic [5:0] wr_addr;

  assign cmd_load = sclk_fall & (bit_cnt_q == CTCR_LAST_CMD_BIT);
  assign wr_stb = sclk_fall & (bit_cnt_q == CTCR_LAST_DATA_BIT) & ~cmd_q[CTCR_CMD_READ_BIT];
  assign wr_data = {shift_in_q[14:0], din_s};
  assign cmd_addr = wr_data[CTCR_CMD_ADDR_MSB:0];
  assign wr_addr = cmd_q[CTCR_CMD_ADDR_MSB:0];

  // a select released mid-frame aborts it; with select tied low frames run back to back
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || cs_n_s) begin
      bit_cnt_q <= 5'h00;
      shift_in_q <= 16'h0000;
    end else if (sclk_fall) begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
      shift_in_q <= wr_data;
    end
  end

  // command latched once its last bit is in
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      cmd_q <= 16'h0000;
    end else if (cmd_load) begin
      cmd_q <= wr_data;
    end
  end

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] ofs_low_q;
  logic [15:0] gain_high_q;
  logic [7:0] gain_low_q;
  logic [15:0] spare_q;
  logic [15:0] chk_q;
  logic cov_wr_q;
  logic [15:0] chk_sum;

  // offset trim low keeps only its upper byte
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ofs_low_q <= CTCR_RST_OFFSET_TRIM_LOW;
    end else if (wr_stb && wr_addr == CTCR_OFS_CH2_OFFSET_TRIM_LOW) begin
      ofs_low_q <= wr_data[CTCR_TRIM_LOW_MSB:CTCR_TRIM_LOW_LSB];
    end
  end

  // gain trim high is a full read-write word
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      gain_high_q <= CTCR_RST_GAIN_TRIM_HIGH;
    end else if (wr_stb && wr_addr == CTCR_OFS_CH2_GAIN_TRIM_HIGH) begin
      gain_high_q <= wr_data;
    end
  end

  // gain trim low keeps only its upper byte
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      gain_low_q <= CTCR_RST_GAIN_TRIM_LOW;
    end else if (wr_stb && wr_addr == CTCR_OFS_CH2_GAIN_TRIM_LOW) begin
      gain_low_q <= wr_data[CTCR_TRIM_LOW_MSB:CTCR_TRIM_LOW_LSB];
    end
  end

  // spare word is stored as written; the host is expected to write zero only
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      spare_q <= CTCR_RST_SPARE_WORD;
    end else if (wr_stb && wr_addr == CTCR_OFS_SPARE_WORD) begin
      spare_q <= wr_data;
    end
  end

  // rotate-and-xor fold; cheap, and catches any single flipped bit
  assign chk_sum = gain_high_q ^ {ofs_low_q, gain_low_q} ^ {spare_q[7:0], spare_q[15:8]};

  // refresh one cycle after a covered write lands; stays zero until the first write
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      cov_wr_q <= 1'b0;
      chk_q <= CTCR_RST_CONFIG_CHECKSUM;
    end else begin
      cov_wr_q <= wr_stb && wr_addr != CTCR_OFS_CONFIG_CHECKSUM;
      if (cov_wr_q) begin
        chk_q <= chk_sum;
      end
    end
  end

  // ---------------------------------------------------------------
  // read mux and output shifter
  // ---------------------------------------------------------------
  logic [15:0] rd_word;
  logic [15:0] dout_sr_q;
  logic dout_q;
  logic oe_n_q;

  // reserved low bytes and unmapped addresses read as zero
  always_comb begin
    rd_word = CTCR_RSVD_ZERO;
    unique case (cmd_addr)
      CTCR_OFS_CH2_OFFSET_TRIM_LOW: rd_word = {ofs_low_q, 8'h00};
      CTCR_OFS_CH2_GAIN_TRIM_HIGH: rd_word = gain_high_q;
      CTCR_OFS_CH2_GAIN_TRIM_LOW: rd_word = {gain_low_q, 8'h00};
      CTCR_OFS_CONFIG_CHECKSUM: rd_word = chk_q;
      CTCR_OFS_SPARE_WORD: rd_word = spare_q;
      default: rd_word = CTCR_RSVD_ZERO;
    endcase
  end

  // data changes on the rising edge so the host can sample on the falling one
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST || cs_n_s) begin
      dout_sr_q <= 16'h0000;
      dout_q <= 1'b0;
    end else if (cmd_load) begin
      dout_sr_q <= wr_data[CTCR_CMD_READ_BIT] ? rd_word : 16'h0000;
    end else if (sclk_rise && bit_cnt_q[4]) begin
      dout_q <= dout_sr_q[15];
      dout_sr_q <= {dout_sr_q[14:0], 1'b0};
    end else if (sclk_rise) begin
      dout_q <= 1'b0;
    end
  end

  // enable follows the synchronised select so a shared line is freed promptly
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      oe_n_q <= 1'b1;
    end else begin
      oe_n_q <= cs_n_s;
    end
  end

  assign O_DOUT = dout_q;
  assign O_DOUT_OE_N = oe_n_q;
  assign O_CH2_OFFSET_TRIM_LOW_BITS = ofs_low_q;
  assign O_CH2_GAIN_TRIM_HIGH_BITS = gain_high_q;
  assign O_CH2_GAIN_TRIM_LOW_BITS = gain_low_q;
  assign O_CONFIG_CHECKSUM = chk_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence seq_reset_release;
    I_RST ##1 !I_RST;
  endsequence

  sequence seq_cov_write;
    wr_stb && wr_addr != CTCR_OFS_CONFIG_CHECKSUM;
  endsequence

  AST_OFS_LOW_READ: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    cmd_load && wr_data[CTCR_CMD_READ_BIT] && cmd_addr == CTCR_OFS_CH2_OFFSET_TRIM_LOW
    |=> dout_sr_q == {ofs_low_q, 8'h00})
    else $error("offset trim low read word wrong");

  AST_GAIN_HIGH_RESET: assert property (@(posedge I_SYS_CLK)
    seq_reset_release |-> O_CH2_GAIN_TRIM_HIGH_BITS == 16'h8000)
    else $error("gain trim high reset value wrong");

  AST_GAIN_HIGH_WRITE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr_stb && wr_addr == CTCR_OFS_CH2_GAIN_TRIM_HIGH
    |=> O_CH2_GAIN_TRIM_HIGH_BITS == $past(wr_data))
    else $error("gain trim high write lost");

  AST_GAIN_LOW_WRITE: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr_stb && wr_addr == CTCR_OFS_CH2_GAIN_TRIM_LOW
    |=> O_CH2_GAIN_TRIM_LOW_BITS == $past(wr_data[15:8]))
    else $error("gain trim low write lost");

  AST_CHK_READ_ONLY: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    wr_stb && wr_addr == CTCR_OFS_CONFIG_CHECKSUM && !cov_wr_q
    |=> ##1 $stable(O_CONFIG_CHECKSUM))
    else $error("checksum changed by a write");

  AST_CHK_RESET: assert property (@(posedge I_SYS_CLK)
    seq_reset_release |-> O_CONFIG_CHECKSUM == 16'h0000)
    else $error("checksum not zero after reset");

  AST_DOUT_HIZ: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    cs_n_s [*2] |-> O_DOUT_OE_N)
    else $error("data out driven while deselected");

  AST_DOUT_DRIVEN: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !cs_n_s [*2] |-> !O_DOUT_OE_N)
    else $error("data out not driven while selected");

  AST_CHK_REFRESH: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    seq_cov_write ##1 1'b1 |=> O_CONFIG_CHECKSUM == $past(chk_sum))
    else $error("checksum not refreshed after write");
endmodule : ctcr_regs

// file: sim/ctcr_host.sv
// host side serial master model for the channel 2 trim register bank
`timescale 1ns/1ns
module ctcr_host (
  input wire logic i_clk,   // system clock, paces the link clock
  input wire logic i_dout,  // resolved serial data out wire
  output logic o_cs_n,      // select for this device alone
  output logic o_sclk,      // link clock, still outside frames
  output logic o_din        // serial data towards the device
);
  // ---------------------------------------------------------------
  // idle levels at time zero
  // ---------------------------------------------------------------
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din = 1'b0;
  end

  // ---------------------------------------------------------------
  // one frame, msb first, data set on rise, sampled by device on fall
  // ---------------------------------------------------------------
  // nbits below 32 aborts the frame by raising select early
  task automatic frame(input logic [31:0] word, input int nbits, output logic [15:0] rd);
    rd = 16'h0000;
    @(posedge i_clk) o_cs_n <= 1'b0;
    repeat (5) @(posedge i_clk);
    for (int b = 31; b > 31 - nbits; b--) begin
      o_sclk <= 1'b1;
      o_din <= word[b];
      repeat (4) @(posedge i_clk); // link clock paced by counting system clocks
      o_sclk <= 1'b0;
      // read late in the low phase, the bit stands until the next rise
      repeat (4) @(posedge i_clk);
      if (b < 16) rd = {rd[14:0], i_dout}; // only this one device is watched
    end
    o_din <= ~o_din; // released data line shows no stale value
    repeat (5) @(posedge i_clk);
    o_cs_n <= 1'b1;
    repeat (6) @(posedge i_clk);
  endtask : frame
endmodule : ctcr_host

// file: sim/test_ctcr_regs.sv
// self-checking bench for the channel 2 trim and checksum register bank
`timescale 1ns/1ns
module test_ctcr_regs;
  import ctcr_pkg::*;
  typedef struct {logic [5:0] a; logic [15:0] d; logic [15:0] e;} ctcr_row_t;
  logic sys_clk, rst, cs_n, sclk, din, dout, oe_n;
  logic dout_last = 1'b0; // last level seen while the device drove the wire
  logic [7:0] ofs_lo, gain_lo;
  logic [15:0] gain_hi, csum, rd;
  wire logic dout_w;
  int fails = 0;
  int checks = 0;
  ctcr_row_t rows [6];

  // ---------------------------------------------------------------
  // clock, wire resolution and instances
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // undriven wire shows the inverse of its last driven level
  always @(posedge sys_clk) if (!oe_n) dout_last <= dout;
  assign dout_w = oe_n ? ~dout_last : dout;
  // host and device run from one shared clock; only the device takes the reset pulse
  ctcr_host i_ctcr_host (.i_clk(sys_clk), .i_dout(dout_w), .o_cs_n(cs_n), .o_sclk(sclk),
    .o_din(din));
  ctcr_regs i_ctcr_regs (.I_SYS_CLK(sys_clk), .I_RST(rst), .I_CS_N(cs_n), .I_SCLK(sclk),
    .I_DIN(din), .O_DOUT(dout), .O_DOUT_OE_N(oe_n), .O_CH2_OFFSET_TRIM_LOW_BITS(ofs_lo),
    .O_CH2_GAIN_TRIM_HIGH_BITS(gain_hi), .O_CH2_GAIN_TRIM_LOW_BITS(gain_lo),
    .O_CONFIG_CHECKSUM(csum));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic wr(input logic [5:0] a, input logic [15:0] d, input int n);
    logic [15:0] r;
    i_ctcr_host.frame({10'h000, a, d}, n, r);
  endtask : wr
  task automatic rdw(input logic [5:0] a, output logic [15:0] r);
    i_ctcr_host.frame({1'b1, 9'h000, a, 16'h0000}, 32, r);
  endtask : rdw
  task automatic do_reset;
    @(posedge sys_clk) rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (6) @(posedge sys_clk);
  endtask : do_reset
  task automatic end_of_test;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // ---------------------------------------------------------------
  // hang guard: far above the few thousand cycles the run needs
  // ---------------------------------------------------------------
  initial begin
    repeat (60000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    rst = 1'b1;
    rows[0] = '{CTCR_OFS_CH2_OFFSET_TRIM_LOW, 16'ha5c3, 16'ha500};
    rows[1] = '{CTCR_OFS_CH2_GAIN_TRIM_HIGH, 16'h1234, 16'h1234};
    rows[2] = '{CTCR_OFS_CH2_GAIN_TRIM_LOW, 16'hffff, 16'hff00};
    rows[3] = '{CTCR_OFS_SPARE_WORD, 16'h0000, 16'h0000};
    rows[4] = '{6'h20, 16'h1111, 16'h0000};
    // checksum folds gain high with the two low trim bytes
    rows[5] = '{CTCR_OFS_CONFIG_CHECKSUM, 16'hbeef, 16'h1234 ^ 16'ha5ff};
    do_reset();
    for (int i = 0; i < 6; i++) begin
      wr(rows[i].a, rows[i].d, 32);
      rdw(rows[i].a, rd);
      check("readback", rd, rows[i].e);
    end
    check("offset_lo", {8'h00, ofs_lo}, 16'h00a5);
    check("gain_hi", gain_hi, 16'h1234);
    check("gain_lo", {8'h00, gain_lo}, 16'h00ff);
    check("idle_oe_n", {15'h0000, oe_n}, 16'h0001);
    // second reset in mid-run brings every word back
    do_reset();
    check("rst_gain_hi", gain_hi, CTCR_RST_GAIN_TRIM_HIGH);
    check("rst_lows", {ofs_lo, gain_lo}, 16'h0000);
    check("rst_csum", csum, CTCR_RST_CONFIG_CHECKSUM);
    check("rst_oe_n", {15'h0000, oe_n}, 16'h0001);
    rdw(CTCR_OFS_SPARE_WORD, rd);
    check("rst_spare", rd, CTCR_RST_SPARE_WORD);
    // aborted write must leave the register untouched
    wr(CTCR_OFS_CH2_GAIN_TRIM_HIGH, 16'h0f0f, 20);
    rdw(CTCR_OFS_CH2_GAIN_TRIM_HIGH, rd);
    check("abort_gain_hi", rd, 16'h8000);
    // rewriting the same value still refreshes the checksum
    wr(CTCR_OFS_CH2_GAIN_TRIM_HIGH, 16'h8000, 32);
    check("csum_port", csum, 16'h8000);
    wr(CTCR_OFS_CONFIG_CHECKSUM, 16'h0000, 32);
    rdw(CTCR_OFS_CONFIG_CHECKSUM, rd);
    check("csum_ro", rd, 16'h8000);
    end_of_test();
  end
endmodule : test_ctcr_regs
